// ### hdl/aijs_consts.svh
/*
 * Constants for the axis interlock and jog select block.
 * Assumes inclusion from the design file only.
 */
`ifndef AIJS_CONSTS_SVH
`define AIJS_CONSTS_SVH

`define AIJS_AXES 4
`define AIJS_ERR_AUTO_HOLD 16'h0004
`define AIJS_ERR_MANUAL_HOLD 16'h0004
`define AIJS_ERR_NONE 16'h0000
`define AIJS_HOLD_RESET 4'hF
`define AIJS_DECEL_CYCLES 8'h10
`define AIJS_INC_CYCLES 16'h0040
`define AIJS_APPROACH_CYCLES 16'h0020

`endif

// ### hdl/aijs_pkg.sv
/*
 * Types for the axis interlock and jog select block.
 * Assumes aijs_consts.svh is on the include path.
 */
package aijs_pkg;
	typedef enum logic [1:0] {
		AIJS_MODE_NONE = 2'h0,
		AIJS_MODE_JOG = 2'h1,
		AIJS_MODE_INC = 2'h2,
		AIJS_MODE_REF = 2'h3
	} aijs_manual_mode_t;

	typedef enum logic [2:0] {
		AIJS_IDLE = 3'h0,
		AIJS_RUN = 3'h1,
		AIJS_HELD = 3'h2,
		AIJS_DECEL = 3'h3,
		AIJS_APPROACH = 3'h4
	} aijs_axis_state_t;

	typedef struct packed {
		logic [3:0] plus;
		logic [3:0] minus;
	} aijs_dir_pair_t;
endpackage

// ### hdl/aijs_top.sv
/*
 * Per-axis motion gating and manual feed select for a four-axis controller.
 * Assumes all control inputs come from an asynchronous sequence program and
 * are synchronised here; automatic motion requests come as level signals.
 */
`include "aijs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module aijs_top #(
	parameter int AXES = `AIJS_AXES
) (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic AUTO_MODE,
	input wire logic [1:0] MANUAL_MODE,
	input wire logic CTRL_RESET,
	input wire aijs_pkg::aijs_dir_pair_t AUTO_MOVE,
	input wire logic AUTO_BLOCK_END,
	input wire logic [3:0] NEAR_DOG,
	input wire aijs_pkg::aijs_dir_pair_t AUTO_HOLD_N,
	input wire aijs_pkg::aijs_dir_pair_t MANUAL_HOLD_N,
	input wire logic [3:0] AUTO_MOTIONLESS_LOCK,
	input wire logic [3:0] MANUAL_MOTIONLESS_LOCK,
	input wire aijs_pkg::aijs_dir_pair_t FEED_SELECT,
	output aijs_pkg::aijs_dir_pair_t MACHINE_MOVE,
	output aijs_pkg::aijs_dir_pair_t COUNTER_STEP,
	output logic [15:0] OP_ERROR,
	output logic [3:0] AXIS_BUSY
);
	initial begin
		if (AXES != `AIJS_AXES) begin
			$error("aijs_top serves exactly four axes");
		end
	end

	// ==========================================================
	// input synchronisers
	localparam int SW = 53;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic [SW-1:0] raw;
	assign raw = {AUTO_MODE, MANUAL_MODE, CTRL_RESET, AUTO_MOVE, AUTO_BLOCK_END, NEAR_DOG,
		AUTO_HOLD_N, MANUAL_HOLD_N, AUTO_MOTIONLESS_LOCK, MANUAL_MOTIONLESS_LOCK,
		FEED_SELECT, 4'h0};

	// holds preset to released so unused axes never stall
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			sync1 <= {17'h00000, 8'hFF, 8'hFF, 8'h00, 8'h00, 4'h0};
			sync2 <= {17'h00000, 8'hFF, 8'hFF, 8'h00, 8'h00, 4'h0};
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	logic auto_mode;
	logic [1:0] manual_mode;
	logic ctrl_reset;
	aijs_pkg::aijs_dir_pair_t auto_move;
	logic block_end;
	logic [3:0] near_dog;
	aijs_pkg::aijs_dir_pair_t ahold_n;
	aijs_pkg::aijs_dir_pair_t mhold_n;
	logic [3:0] alock_in;
	logic [3:0] mlock_in;
	aijs_pkg::aijs_dir_pair_t fsel;
	logic [3:0] pad;
	assign {auto_mode, manual_mode, ctrl_reset, auto_move, block_end, near_dog, ahold_n,
		mhold_n, alock_in, mlock_in, fsel, pad} = sync2;

	// ==========================================================
	// direction decode and select edge qualification
	logic [3:0] sel_plus;
	logic [3:0] sel_minus;
	logic [3:0] sel_any;
	assign sel_plus = fsel.plus & ~fsel.minus;
	assign sel_minus = fsel.minus & ~fsel.plus;
	assign sel_any = sel_plus | sel_minus;

	logic [3:0] sel_armed;
	logic [3:0] sel_prev;
	logic [3:0] decel_busy;
	logic manual_on;
	assign manual_on = (manual_mode != aijs_pkg::AIJS_MODE_NONE) && !auto_mode;

	// a select seen high while not qualified stays disarmed until it drops
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			sel_prev <= 4'hF;
			sel_armed <= 4'h0;
		end else begin
			sel_prev <= sel_any;
			for (int i = 0; i < AXES; i++) begin
				if (!sel_any[i]) begin
					sel_armed[i] <= 1'b1;
				end else if (ctrl_reset || !manual_on || decel_busy[i]) begin
					sel_armed[i] <= 1'b0;
				end
			end
		end
	end

	logic [3:0] sel_start;
	assign sel_start = sel_any & ~sel_prev & sel_armed & ~decel_busy
		& {4{manual_on & ~ctrl_reset}};

	// ==========================================================
	// lock latching: auto at block boundaries, manual when all stopped
	logic [3:0] alock;
	logic [3:0] mlock;
	logic all_stopped;
	logic auto_in_block;

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			alock <= 4'h0;
		end else if (!auto_in_block || block_end) begin
			alock <= alock_in;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			mlock <= 4'h0;
		end else if (all_stopped) begin
			mlock <= mlock_in;
		end
	end

	// ==========================================================
	// automatic hold: any hit stalls every axis
	logic [3:0] auto_hit;
	logic auto_stall;
	assign auto_hit = (auto_move.plus & ~ahold_n.plus) | (auto_move.minus & ~ahold_n.minus);
	assign auto_stall = auto_mode && (auto_hit != 4'h0);
	assign auto_in_block = auto_mode && ((auto_move.plus | auto_move.minus) != 4'h0);

	// ==========================================================
	// per-axis manual motion
	aijs_pkg::aijs_axis_state_t st [4];
	logic [3:0] dir_minus;
	logic [15:0] cnt [4];
	logic [3:0] man_hit;
	logic [3:0] man_moving;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_axis
			assign man_hit[g] = dir_minus[g] ? !mhold_n.minus[g] : !mhold_n.plus[g];
			assign man_moving[g] = (st[g] == aijs_pkg::AIJS_RUN) || (st[g] == aijs_pkg::AIJS_APPROACH);
			assign decel_busy[g] = (st[g] == aijs_pkg::AIJS_DECEL);

			always_ff @(posedge REF_CLK or negedge NRST) begin
				if (!NRST) begin
					st[g] <= aijs_pkg::AIJS_IDLE;
					dir_minus[g] <= 1'b0;
					cnt[g] <= 16'h0000;
				end else if (ctrl_reset) begin
					st[g] <= aijs_pkg::AIJS_IDLE;
					cnt[g] <= 16'h0000;
				end else begin
					case (st[g])
						aijs_pkg::AIJS_IDLE: begin
							if (sel_start[g]) begin
								dir_minus[g] <= sel_minus[g];
								cnt[g] <= (manual_mode == aijs_pkg::AIJS_MODE_INC)
									? `AIJS_INC_CYCLES : 16'h0000;
								st[g] <= aijs_pkg::AIJS_RUN;
							end
						end
						aijs_pkg::AIJS_RUN, aijs_pkg::AIJS_HELD: begin
							// a held axis keeps its pending move and restarts on release
							st[g] <= man_hit[g] ? aijs_pkg::AIJS_HELD : aijs_pkg::AIJS_RUN;
							if (manual_mode == aijs_pkg::AIJS_MODE_INC) begin
								if (!man_hit[g]) begin
									cnt[g] <= cnt[g] - 16'h0001;
								end
								if (!man_hit[g] && cnt[g] == 16'h0001) begin
									cnt[g] <= 16'(`AIJS_DECEL_CYCLES);
									st[g] <= aijs_pkg::AIJS_DECEL;
								end
							end else if (manual_mode == aijs_pkg::AIJS_MODE_REF
									&& near_dog[g] && !man_hit[g]) begin
								cnt[g] <= `AIJS_APPROACH_CYCLES;
								st[g] <= aijs_pkg::AIJS_APPROACH;
							end else if (!(dir_minus[g] ? sel_minus[g] : sel_plus[g])
									|| !manual_on) begin
								cnt[g] <= 16'(`AIJS_DECEL_CYCLES);
								st[g] <= aijs_pkg::AIJS_DECEL;
							end
						end
						aijs_pkg::AIJS_APPROACH: begin
							if (!man_hit[g]) begin
								cnt[g] <= cnt[g] - 16'h0001;
								if (cnt[g] == 16'h0001) begin
									cnt[g] <= 16'(`AIJS_DECEL_CYCLES);
									st[g] <= aijs_pkg::AIJS_DECEL;
								end
							end
						end
						aijs_pkg::AIJS_DECEL: begin
							cnt[g] <= cnt[g] - 16'h0001;
							if (cnt[g] == 16'h0001) begin
								st[g] <= aijs_pkg::AIJS_IDLE;
							end
						end
						default: begin
							st[g] <= aijs_pkg::AIJS_IDLE;
						end
					endcase
				end
			end
		end
	endgenerate

	assign all_stopped = (st[0] == aijs_pkg::AIJS_IDLE) && (st[1] == aijs_pkg::AIJS_IDLE)
		&& (st[2] == aijs_pkg::AIJS_IDLE) && (st[3] == aijs_pkg::AIJS_IDLE);

	// ==========================================================
	// outputs
	logic [3:0] man_plus_go;
	logic [3:0] man_minus_go;
	logic [3:0] auto_plus_go;
	logic [3:0] auto_minus_go;
	assign man_plus_go = man_moving & ~dir_minus & ~man_hit;
	assign man_minus_go = man_moving & dir_minus & ~man_hit;
	assign auto_plus_go = auto_mode && !auto_stall ? auto_move.plus : 4'h0;
	assign auto_minus_go = auto_mode && !auto_stall ? auto_move.minus : 4'h0;

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			COUNTER_STEP <= '0;
			MACHINE_MOVE <= '0;
		end else begin
			COUNTER_STEP.plus <= auto_plus_go | man_plus_go;
			COUNTER_STEP.minus <= auto_minus_go | man_minus_go;
			MACHINE_MOVE.plus <= (auto_plus_go & ~alock) | (man_plus_go & ~mlock);
			MACHINE_MOVE.minus <= (auto_minus_go & ~alock) | (man_minus_go & ~mlock);
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			OP_ERROR <= `AIJS_ERR_NONE;
			AXIS_BUSY <= 4'h0;
		end else begin
			AXIS_BUSY <= ~{4{all_stopped}} & {st[3] != aijs_pkg::AIJS_IDLE,
				st[2] != aijs_pkg::AIJS_IDLE, st[1] != aijs_pkg::AIJS_IDLE,
				st[0] != aijs_pkg::AIJS_IDLE};
			if (auto_stall) begin
				OP_ERROR <= `AIJS_ERR_AUTO_HOLD;
			end else if ((man_hit & (man_moving | (st[0] == aijs_pkg::AIJS_HELD ? 4'h1 : 4'h0)
					| {st[3] == aijs_pkg::AIJS_HELD, st[2] == aijs_pkg::AIJS_HELD,
					st[1] == aijs_pkg::AIJS_HELD, st[0] == aijs_pkg::AIJS_HELD})) != 4'h0) begin
				OP_ERROR <= `AIJS_ERR_MANUAL_HOLD;
			end else begin
				OP_ERROR <= `AIJS_ERR_NONE;
			end
		end
	end
endmodule // aijs_top

`default_nettype wire

// ### verif/aijs_checker_assertions.sv
/* aijs_checker: port-level properties of aijs_top.
   Assumes a bind from the bench; one clock, NRST async active low. */
`timescale 1ns/1ps
`default_nettype none
module aijs_checker (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic AUTO_MODE,
	input wire logic [1:0] MANUAL_MODE,
	input wire aijs_pkg::aijs_dir_pair_t AUTO_HOLD_N,
	input wire aijs_pkg::aijs_dir_pair_t MANUAL_HOLD_N,
	input wire aijs_pkg::aijs_dir_pair_t MACHINE_MOVE,
	input wire aijs_pkg::aijs_dir_pair_t COUNTER_STEP,
	input wire logic [15:0] OP_ERROR,
	input wire logic [3:0] AXIS_BUSY
);
	// ==========
	// properties
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	wire logic mh_lo = MANUAL_MODE == 2'h1 && !MANUAL_HOLD_N.minus[1];
	property p_auto_min;
		AUTO_MODE && MACHINE_MOVE.minus[2] && !AUTO_HOLD_N.minus[2] |-> ##[1:8] OP_ERROR == 16'h0004;
	endproperty
	a_auto_min: assert property (p_auto_min) else $error("auto minus hold ignored");
	property p_auto_all;
		AUTO_MODE && MACHINE_MOVE.plus[2] && !AUTO_HOLD_N.plus[2] |-> ##[1:24] MACHINE_MOVE == 8'h00;
	endproperty
	a_auto_all: assert property (p_auto_all) else $error("axes kept moving");
	property p_man_plus;
		MANUAL_MODE == 2'h1 && MACHINE_MOVE.plus[0] && !MANUAL_HOLD_N.plus[0] |-> ##[1:8] OP_ERROR == 16'h0004;
	endproperty
	a_man_plus: assert property (p_man_plus) else $error("manual plus hold ignored");
	property p_held_err;
		(mh_lo && AXIS_BUSY[1] && MACHINE_MOVE == 8'h00)[*8] |-> OP_ERROR == 16'h0004;
	endproperty
	a_held_err: assert property (p_held_err) else $error("held axis without error");
	property p_man_min;
		mh_lo[*8] ##1 mh_lo[*8] ##1 mh_lo[*8] |-> !MACHINE_MOVE.minus[1];
	endproperty
	a_man_min: assert property (p_man_min) else $error("manual minus hold ignored");
	property p_boot;
		$rose(NRST) |-> OP_ERROR == 16'h0000 && AXIS_BUSY == 4'h0;
	endproperty
	a_boot: assert property (p_boot) else $error("not quiet after reset");
	property p_count;
		(MACHINE_MOVE & ~COUNTER_STEP) == 8'h00;
	endproperty
	a_count: assert property (p_count) else $error("motion without count");
	property p_no_mode;
		(MANUAL_MODE == 2'h0)[*4] ##0 AXIS_BUSY == 4'h0 |=> AXIS_BUSY == 4'h0;
	endproperty
	a_no_mode: assert property (p_no_mode) else $error("started without mode");
endmodule // aijs_checker
`default_nettype wire

// ### verif/aijs_plc_model.sv
/* aijs_plc_model: sequence program side driving hold, lock and select bits.
   Assumes the bench calls apply; bits change on the falling edge only. */
`timescale 1ns/1ps
`default_nettype none
module aijs_plc_model (
	input wire logic REF_CLK,
	output var aijs_pkg::aijs_dir_pair_t AUTO_HOLD_N,
	output var aijs_pkg::aijs_dir_pair_t MANUAL_HOLD_N,
	output var aijs_pkg::aijs_dir_pair_t FEED_SELECT,
	output var logic [3:0] AUTO_MOTIONLESS_LOCK,
	output var logic [3:0] MANUAL_MOTIONLESS_LOCK
);
	// ==========
	// power-up values: holds released so unused axes never stall
	initial begin
		AUTO_HOLD_N = 8'hFF;
		MANUAL_HOLD_N = 8'hFF;
		FEED_SELECT = 8'h00;
		AUTO_MOTIONLESS_LOCK = 4'h0;
		MANUAL_MOTIONLESS_LOCK = 4'h0;
	end
	task automatic apply(input logic [7:0] a, m, s, input logic [3:0] l);
		@(negedge REF_CLK);
		AUTO_HOLD_N = a;
		MANUAL_HOLD_N = m;
		FEED_SELECT = s;
		AUTO_MOTIONLESS_LOCK = l;
	endtask
endmodule // aijs_plc_model
`default_nettype wire

// ### verif/tb_top.sv
/* tb_top: directed scenarios for aijs_top.
   Assumes the plc model and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic auto_mode = 1'b0;
	logic [1:0] mode = 2'h0;
	logic ctl = 1'b0;
	logic [3:0] dog = 4'h0;
	aijs_pkg::aijs_dir_pair_t auto_move = 8'h00;
	aijs_pkg::aijs_dir_pair_t ah, mh, sel, mv, cs;
	logic [3:0] al, ml, busy;
	logic [15:0] err;
	int errors = 0;
	int check_count = 0;
	always #20 ref_clk = ~ref_clk;
	aijs_plc_model i_aijs_plc_model (.REF_CLK(ref_clk), .AUTO_HOLD_N(ah), .MANUAL_HOLD_N(mh),
		.FEED_SELECT(sel), .AUTO_MOTIONLESS_LOCK(al), .MANUAL_MOTIONLESS_LOCK(ml));
	// block end stays idle: auto locks latch between blocks instead
	aijs_top i_aijs_top (.REF_CLK(ref_clk), .NRST(nrst), .AUTO_MODE(auto_mode),
		.MANUAL_MODE(mode), .CTRL_RESET(ctl), .AUTO_MOVE(auto_move), .AUTO_BLOCK_END(1'b0),
		.NEAR_DOG(dog), .AUTO_HOLD_N(ah), .MANUAL_HOLD_N(mh), .AUTO_MOTIONLESS_LOCK(al),
		.MANUAL_MOTIONLESS_LOCK(ml), .FEED_SELECT(sel), .MACHINE_MOVE(mv),
		.COUNTER_STEP(cs), .OP_ERROR(err), .AXIS_BUSY(busy));
	// ==========
	// helpers
	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task pm(input logic [7:0] a, m, s, input logic [3:0] l);
		i_aijs_plc_model.apply(a, m, s, l);
	endtask
	task chk(input string n, input logic [15:0] s, e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// ==========
	// scenarios
	task t_jog();
		mode = 2'h1;
		pm(8'hFF, 8'hFF, 8'h10, 4'h0);
		cyc(6);
		chk("move", mv, 8'h10);
		pm(8'hFF, 8'hEF, 8'h10, 4'h0);
		cyc(26);
		chk("error", err, 16'h0004);
		chk("move", mv, 8'h00);
		pm(8'hFF, 8'hFF, 8'h10, 4'h0);
		cyc(6);
		chk("move", mv, 8'h10);
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		// re-raise in mid-deceleration must not restart the axis
		cyc(8);
		pm(8'hFF, 8'hFF, 8'h10, 4'h0);
		cyc(30);
		chk("busy", busy, 4'h0);
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		$display("jog done");
	endtask
	task t_minus();
		pm(8'hFF, 8'hFD, 8'h02, 4'h0);
		cyc(26);
		chk("move", mv, 8'h00);
		chk("error", err, 16'h0004);
		pm(8'hFF, 8'hFF, 8'h02, 4'h0);
		cyc(6);
		chk("move", mv, 8'h02);
		pm(8'hFF, 8'hFF, 8'h22, 4'h0);
		cyc(30);
		chk("busy", busy, 4'h0);
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		mode = 2'h0;
		pm(8'hFF, 8'hFF, 8'h10, 4'h0);
		cyc(4);
		mode = 2'h1;
		cyc(8);
		chk("busy", busy, 4'h0);
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		$display("minus done");
	endtask
	task t_inc();
		mode = 2'h2;
		pm(8'hFF, 8'hFF, 8'h10, 4'h0);
		cyc(6);
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		cyc(30);
		chk("move", mv, 8'h10);
		cyc(70);
		chk("busy", busy, 4'h0);
		$display("inc done");
	endtask
	task t_ref();
		mode = 2'h1;
		ctl = 1'b1;
		pm(8'hFF, 8'hFF, 8'h10, 4'h0);
		cyc(4);
		ctl = 1'b0;
		cyc(8);
		chk("busy", busy, 4'h0);
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		pm(8'hFF, 8'hFF, 8'h10, 4'h0);
		cyc(6);
		chk("move", mv, 8'h10);
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		cyc(24);
		mode = 2'h3;
		pm(8'hFF, 8'hFF, 8'h20, 4'h0);
		cyc(6);
		dog = 4'h2;
		cyc(4);
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		dog = 4'h0;
		cyc(10);
		chk("move", mv, 8'h20);
		cyc(40);
		chk("busy", busy, 4'h0);
		$display("ref done");
	endtask
	task t_auto();
		mode = 2'h0;
		auto_mode = 1'b1;
		auto_move = 8'h40;
		pm(8'hBF, 8'hFF, 8'h00, 4'h0);
		cyc(30);
		chk("move", mv, 8'h00);
		chk("error", err, 16'h0004);
		auto_move = 8'h04;
		pm(8'hFF, 8'hFF, 8'h00, 4'h0);
		cyc(6);
		chk("move", mv, 8'h04);
		pm(8'hFB, 8'hFF, 8'h00, 4'h0);
		cyc(30);
		chk("error", err, 16'h0004);
		auto_move = 8'h00;
		pm(8'hFF, 8'hFF, 8'h00, 4'h4);
		cyc(4);
		auto_move = 8'h40;
		cyc(6);
		chk("count", cs, 8'h40);
		chk("move", mv, 8'h00);
		$display("auto done");
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		cyc(20);
		nrst = 1'b1;
		cyc(2);
		t_jog();
		t_minus();
		t_inc();
		t_ref();
		t_auto();
		close_out();
	end
	// about 500 cycles expected; cut off at 3000
	initial begin
		#120000;
		errors++;
		close_out();
	end
endmodule // tb_top
bind aijs_top aijs_checker i_aijs_checker (.REF_CLK(REF_CLK), .NRST(NRST),
	.AUTO_MODE(AUTO_MODE), .MANUAL_MODE(MANUAL_MODE), .AUTO_HOLD_N(AUTO_HOLD_N),
	.MANUAL_HOLD_N(MANUAL_HOLD_N), .MACHINE_MOVE(MACHINE_MOVE),
	.COUNTER_STEP(COUNTER_STEP), .OP_ERROR(OP_ERROR), .AXIS_BUSY(AXIS_BUSY));
`default_nettype wire
